// ==== dma_req_pkg.sv ====
// Constants, types and register map of the FIFO DMA request logic
// Function
// - DMA on bit low: no DMA activity, request line held inactive.
// - On-bit falling during a transfer resets engine and pulses stop line.
// - Bits 12:8 of output-limit register, reset 7, set stop pulse length.
// - Control bit 2, reset 0: 1 demand mode, 0 block/step/burst mode.
// - Control bit 0, reset 1: 1 serves input FIFO, 0 output FIFO.
// - One channel only: only the selected FIFO moves by DMA.
// - Acknowledges gated by write or read strobe matching the direction.
// - Offset 0x88 holds the input FIFO low limit in low bits.
// - Offset 0x8c holds output FIFO high limit at bit 16 plus stop length.
// - Input trigger met when input load is at or below low limit.
// - Output trigger met when output load is at or above high limit.
// - Demand size: depth minus load for input, load for output.
// - DMA limits are independent of flow-control flag thresholds.
// - Output high limit one: every new output word raises a request.
// - Soft reset aborts DMA stream and flushes the FIFOs.
// - Consumers stall until a whole packet is available or fits.
// - Demand mode: load counter, request while counting down, repeat.
// - Edge modes: drop request on first qualified ack, re-raise after.
// - Once disabled, request goes inactive even with FIFO needs pending.
package dma_req_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_IN_LIMIT   = 8'h88;
	localparam logic [7:0] OFF_OUT_LIMIT  = 8'h8c;
	localparam logic [7:0] OFF_CONTROL    = 8'h90;
	localparam logic [7:0] OFF_STATUS     = 8'h94;

	// Field positions
	localparam int IN_LIMIT_LSB     = 0;
	localparam int OUT_LIMIT_LSB    = 16;
	localparam int STOP_LEN_LSB     = 8;
	localparam int STOP_LEN_W       = 5;
	localparam int STAT_REQ_BIT     = 0;
	localparam int STAT_STOP_BIT    = 1;
	localparam int STAT_STATE_LSB   = 4;
	localparam int STAT_COUNT_LSB   = 16;

	// Values after reset
	localparam logic [7:0] IN_LIMIT_RST   = 8'h0a;
	localparam logic [7:0] OUT_LIMIT_RST  = 8'h3c;
	localparam logic [4:0] STOP_LEN_RST   = 5'h07;
	localparam logic       HANDSHAKE_RST  = 1'b0;
	localparam logic       ON_RST         = 1'b0;
	localparam logic       FIFO_SEL_RST   = 1'b1;

	// Control register, bits 2:0
	typedef struct packed {
		logic handshake;
		logic on;
		logic fifo_sel;
	} dma_ctrl_t;

	// Host side pins, all active low
	typedef struct packed {
		logic ack_n;
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} host_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_DEMAND   = 3'b001,
		ST_EDGE_REQ = 3'b010,
		ST_STOP     = 3'b011
	} engine_state_t;

endpackage : dma_req_pkg

// ==== pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int             W        = 4,
	parameter logic [W-1:0]   IDLE_VAL = '1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Pins in, filtered levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= IDLE_VAL;
			s2_reg   <= IDLE_VAL;
			s3_reg   <= IDLE_VAL;
			q_reg    <= IDLE_VAL;
		end else begin
			meta_reg <= d;
			s2_reg   <= meta_reg;
			s3_reg   <= s2_reg;
			// Bit-wise: a change counts once stages two and three agree
			q_reg    <= (s2_reg & s3_reg) | (q_reg & (s2_reg ^ s3_reg));
		end
	end

	assign q = q_reg;

endmodule : pin_sync

// ==== stop_pulse_timer.sv ====
// Stop line pulse generator of programmable length
`timescale 1ns/1ps
module stop_pulse_timer #(
	parameter int LEN_W = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Start request and pulse length
	input  wire logic             start,
	input  wire logic [LEN_W-1:0] length,
	// Pulse output
	output logic                  active
);
	logic             active_reg;
	logic [LEN_W-1:0] cnt_reg;
	logic             load;
	logic             last;

	assign load = start && (length != '0);
	assign last = active_reg && (cnt_reg == '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= 1'b0;
			cnt_reg    <= '0;
		end else if (load) begin
			active_reg <= 1'b1;
			cnt_reg    <= length - 1'b1;
		end else if (last) begin
			active_reg <= 1'b0;
		end else if (active_reg) begin
			cnt_reg    <= cnt_reg - 1'b1;
		end
	end

	assign active = active_reg;

endmodule : stop_pulse_timer

// ==== fifo_dma_request_control.sv ====
// Device-side DMA request engine for the input and output FIFOs
`timescale 1ns/1ps
module fifo_dma_request_control #(
	parameter int FIFO_DEPTH = 64,
	parameter int LOAD_W     = $clog2(FIFO_DEPTH) + 1
) (
	// Clock and reset
	input  wire logic                    CLK_SYS,
	input  wire logic                    RST_N,
	// Register port
	input  wire logic [7:0]              REG_ADDR,
	input  wire logic [31:0]             REG_WDATA,
	input  wire logic                    REG_WR,
	input  wire logic                    REG_RD,
	output logic      [31:0]             REG_RDATA,
	// Host DMA handshake pins
	input  wire dma_req_pkg::host_pins_t HOST_PINS,
	output logic                         DMA_REQUEST,
	output logic                         DMA_STOP,
	// FIFO status and command side
	input  wire logic [LOAD_W-1:0]       IN_FIFO_LOAD,
	input  wire logic [LOAD_W-1:0]       OUT_FIFO_LOAD,
	input  wire logic [LOAD_W-1:0]       PACKET_WORDS,
	input  wire logic                    SOFT_RESET_CMD,
	// Datapath strobes and consumer status
	output logic                         IN_FIFO_DMA_WRITE,
	output logic                         OUT_FIFO_DMA_READ,
	output logic                         FIFO_FLUSH,
	output logic                         IN_PACKET_READY,
	output logic                         OUT_PACKET_ROOM
);
	import dma_req_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisation

	logic       rst_meta_reg;
	logic       rst_n_reg;
	host_pins_t pins_f;
	logic       ack_prev_reg;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	pin_sync #(
		.W        (4),
		.IDLE_VAL (4'hf)
	) u_pin_sync (
		.clk   (CLK_SYS),
		.rst_n (rst_n_reg),
		.d     (HOST_PINS),
		.q     (pins_f)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	localparam logic [LOAD_W-1:0] DEPTH_L = LOAD_W'(FIFO_DEPTH);

	logic [LOAD_W-1:0]     in_limit_reg;
	logic [LOAD_W-1:0]     out_limit_reg;
	logic [STOP_LEN_W-1:0] stop_len_reg;
	dma_ctrl_t             ctrl_reg;
	logic [31:0]           rdata_reg;
	logic [31:0]           rd_mux;
	logic [31:0]           rd_in;
	logic [31:0]           rd_out;
	logic [31:0]           rd_ctrl;
	logic [31:0]           rd_stat;
	logic                  wr_in;
	logic                  wr_out;
	logic                  wr_ctrl;

	engine_state_t         state_reg;
	engine_state_t         state_next;
	logic [LOAD_W-1:0]     count_reg;
	logic [LOAD_W-1:0]     count_next;
	logic                  req_reg;
	logic                  stop_active;

	assign wr_in   = REG_WR && hit(REG_ADDR, OFF_IN_LIMIT);
	assign wr_out  = REG_WR && hit(REG_ADDR, OFF_OUT_LIMIT);
	assign wr_ctrl = REG_WR && hit(REG_ADDR, OFF_CONTROL);

	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			in_limit_reg  <= LOAD_W'(IN_LIMIT_RST);
			out_limit_reg <= LOAD_W'(OUT_LIMIT_RST);
			stop_len_reg  <= STOP_LEN_RST;
			ctrl_reg      <= '{HANDSHAKE_RST, ON_RST, FIFO_SEL_RST};
		end else begin
			if (wr_in)
				in_limit_reg <= REG_WDATA[IN_LIMIT_LSB +: LOAD_W];
			if (wr_out) begin
				out_limit_reg <= REG_WDATA[OUT_LIMIT_LSB +: LOAD_W];
				stop_len_reg  <= REG_WDATA[STOP_LEN_LSB +: STOP_LEN_W];
			end
			if (wr_ctrl)
				ctrl_reg <= dma_ctrl_t'(REG_WDATA[2:0]);
		end
	end

	assign rd_in   = 32'(in_limit_reg) << IN_LIMIT_LSB;
	assign rd_out  = (32'(out_limit_reg) << OUT_LIMIT_LSB)
	               | (32'(stop_len_reg) << STOP_LEN_LSB);
	assign rd_ctrl = 32'(ctrl_reg);
	assign rd_stat = (32'(count_reg) << STAT_COUNT_LSB)
	               | (32'(state_reg) << STAT_STATE_LSB)
	               | (32'(stop_active) << STAT_STOP_BIT)
	               | (32'(req_reg) << STAT_REQ_BIT);

	assign rd_mux = hit(REG_ADDR, OFF_IN_LIMIT)  ? rd_in   :
	                hit(REG_ADDR, OFF_OUT_LIMIT) ? rd_out  :
	                hit(REG_ADDR, OFF_CONTROL)   ? rd_ctrl :
	                hit(REG_ADDR, OFF_STATUS)    ? rd_stat : 32'h0000_0000;

	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg)
			rdata_reg <= 32'h0000_0000;
		else
			rdata_reg <= REG_RD ? rd_mux : 32'h0000_0000;
	end

	assign REG_RDATA = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Trigger, size and acknowledge qualification

	logic              in_trig;
	logic              out_trig;
	logic              trig;
	logic [LOAD_W-1:0] in_free;
	logic [LOAD_W-1:0] demand_words;
	logic              ack_fall;
	logic              dir_strobe;
	logic              ack_ok;
	logic              in_progress;
	logic              en_prev_reg;
	logic              en_fell;
	logic              stop_start;
	logic              start_ok;

	// Own limits only; flow-control flag thresholds live elsewhere
	assign in_trig  = IN_FIFO_LOAD <= in_limit_reg;
	assign out_trig = OUT_FIFO_LOAD >= out_limit_reg;
	assign trig     = ctrl_reg.fifo_sel ? in_trig : out_trig;

	assign in_free      = DEPTH_L - IN_FIFO_LOAD;
	assign demand_words = ctrl_reg.fifo_sel ? in_free : OUT_FIFO_LOAD;

	assign ack_fall   = ack_prev_reg && !pins_f.ack_n && !pins_f.cs_n;
	assign dir_strobe = ctrl_reg.fifo_sel ? !pins_f.wr_n : !pins_f.rd_n;
	assign ack_ok     = ctrl_reg.on && ack_fall && dir_strobe;

	assign in_progress = (state_reg == ST_DEMAND)
	                  || (state_reg == ST_EDGE_REQ);
	assign en_fell     = en_prev_reg && !ctrl_reg.on;
	// Soft reset also aborts the host controller mid-transfer
	assign stop_start  = (en_fell || SOFT_RESET_CMD) && in_progress;
	assign start_ok    = (state_reg == ST_IDLE) && ctrl_reg.on
	                  && !stop_active && trig && !SOFT_RESET_CMD;

	////////////////////////////////////////////////////////////////////////
	// Request engine

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		if (stop_start) begin
			state_next = ST_STOP;
			count_next = '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_ok && ctrl_reg.handshake) begin
						if (demand_words != '0) begin
							state_next = ST_DEMAND;
							count_next = demand_words;
						end
					end else if (start_ok) begin
						state_next = ST_EDGE_REQ;
					end
				end
				ST_DEMAND: begin
					if (ack_ok) begin
						if (count_reg == LOAD_W'(1)) begin
							state_next = ST_IDLE;
							count_next = '0;
						end else begin
							count_next = count_reg - 1'b1;
						end
					end
				end
				ST_EDGE_REQ: begin
					if (ack_ok)
						state_next = ST_IDLE;
				end
				ST_STOP: begin
					if (!stop_active)
						state_next = ST_IDLE;
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg    <= ST_IDLE;
			count_reg    <= '0;
			req_reg      <= 1'b0;
			en_prev_reg  <= ON_RST;
			ack_prev_reg <= 1'b1;
		end else begin
			state_reg    <= state_next;
			count_reg    <= count_next;
			req_reg      <= ctrl_reg.on && ((state_next == ST_DEMAND)
			             || (state_next == ST_EDGE_REQ));
			en_prev_reg  <= ctrl_reg.on;
			ack_prev_reg <= pins_f.ack_n;
		end
	end

	stop_pulse_timer #(
		.LEN_W (STOP_LEN_W)
	) u_stop_timer (
		.clk    (CLK_SYS),
		.rst_n  (rst_n_reg),
		.start  (stop_start),
		.length (stop_len_reg),
		.active (stop_active)
	);

	////////////////////////////////////////////////////////////////////////
	// Datapath strobes and consumer status

	logic in_xfer_reg;
	logic out_xfer_reg;
	logic flush_reg;
	logic in_ready_reg;
	logic out_room_reg;

	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			in_xfer_reg  <= 1'b0;
			out_xfer_reg <= 1'b0;
			flush_reg    <= 1'b0;
			in_ready_reg <= 1'b0;
			out_room_reg <= 1'b0;
		end else begin
			in_xfer_reg  <= ack_ok && ctrl_reg.fifo_sel;
			out_xfer_reg <= ack_ok && !ctrl_reg.fifo_sel;
			flush_reg    <= SOFT_RESET_CMD;
			in_ready_reg <= IN_FIFO_LOAD >= PACKET_WORDS;
			out_room_reg <= (DEPTH_L - OUT_FIFO_LOAD) >= PACKET_WORDS;
		end
	end

	assign DMA_REQUEST       = req_reg;
	assign DMA_STOP          = stop_active;
	assign IN_FIFO_DMA_WRITE = in_xfer_reg;
	assign OUT_FIFO_DMA_READ = out_xfer_reg;
	assign FIFO_FLUSH        = flush_reg;
	assign IN_PACKET_READY   = in_ready_reg;
	assign OUT_PACKET_ROOM   = out_room_reg;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	logic [STOP_LEN_W:0]   stop_run_reg;
	logic [STOP_LEN_W-1:0] stop_len_seen_reg;

	always_ff @(posedge CLK_SYS or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			stop_run_reg      <= '0;
			stop_len_seen_reg <= '0;
		end else begin
			stop_run_reg <= stop_active ? stop_run_reg + 1'b1 : '0;
			if (stop_start)
				stop_len_seen_reg <= stop_len_reg;
		end
	end

	a_off_no_request:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		!ctrl_reg.on |=> !DMA_REQUEST)
	else $error("request active while DMA is off");

	a_disable_stop:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(en_fell && in_progress && stop_len_reg != '0)
		|=> DMA_STOP && !DMA_REQUEST)
	else $error("disable in transfer did not start stop pulse");

	a_stop_length:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		$fell(DMA_STOP) |-> stop_run_reg == (STOP_LEN_W+1)'(stop_len_seen_reg))
	else $error("stop pulse length differs from programmed value");

	a_demand_size:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(state_reg == ST_IDLE && state_next == ST_DEMAND)
		|=> count_reg == $past(demand_words) && DMA_REQUEST)
	else $error("demand count not loaded from FIFO load");

	a_edge_drop:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(state_reg == ST_EDGE_REQ && ack_ok && !stop_start)
		|=> !DMA_REQUEST ##1 (state_reg == ST_IDLE || state_reg == ST_EDGE_REQ))
	else $error("edge mode request not dropped after acknowledge");

	a_input_trigger:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		($rose(DMA_REQUEST) && ctrl_reg.fifo_sel)
		|-> $past(IN_FIFO_LOAD <= in_limit_reg))
	else $error("input request without load at or below limit");

	a_output_trigger:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		($rose(DMA_REQUEST) && !ctrl_reg.fifo_sel)
		|-> $past(OUT_FIFO_LOAD >= out_limit_reg))
	else $error("output request without load at or above limit");

	a_ack_gated:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		(IN_FIFO_DMA_WRITE || OUT_FIFO_DMA_READ) |-> $past(!pins_f.cs_n)
		&& (IN_FIFO_DMA_WRITE ? $past(!pins_f.wr_n) : $past(!pins_f.rd_n)))
	else $error("transfer accepted without matching strobe");

	a_one_channel:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		!(IN_FIFO_DMA_WRITE && OUT_FIFO_DMA_READ))
	else $error("both FIFOs served in one cycle");

	a_soft_abort:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		SOFT_RESET_CMD |=> FIFO_FLUSH && !DMA_REQUEST)
	else $error("soft reset did not flush and drop request");

	a_stop_blocks_req:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		DMA_STOP |-> !DMA_REQUEST)
	else $error("request during stop pulse");

	a_packet_ready:
	assert property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		IN_PACKET_READY |-> $past(IN_FIFO_LOAD >= PACKET_WORDS))
	else $error("packet ready without enough words");

	c_demand_run:
	cover property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		state_reg == ST_DEMAND ##1 state_reg == ST_IDLE);

	c_edge_ack:
	cover property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		state_reg == ST_EDGE_REQ && ack_ok);

	c_stop_pulse:
	cover property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		$fell(DMA_STOP));

	c_soft_reset:
	cover property (@(posedge CLK_SYS) disable iff (!rst_n_reg)
		SOFT_RESET_CMD && in_progress);

endmodule : fifo_dma_request_control

// ==== host_dma_model.sv ====
// Behavioural host DMA controller answering the device request line
`timescale 1ns/1ps
module host_dma_model (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Bench controls: on, direction, fault kind, answer delay
	input  wire logic               enable,
	input  wire logic               to_input,
	input  wire logic [1:0]         fault,
	input  wire logic [3:0]         delay,
	// Handshake with the device
	input  wire logic               dma_req,
	output dma_req_pkg::host_pins_t pins
);
	import dma_req_pkg::*;

	// One word per acknowledge; fault 1 drops chip select, 2 wrong strobe
	initial begin
		pins = '1;
		forever begin
			@(posedge clk);
			if (rst_n && enable && dma_req) begin
				repeat (delay) @(posedge clk);
				pins.cs_n  <= (fault == 2'd1);
				pins.wr_n  <= !(to_input ^ (fault == 2'd2));
				pins.rd_n  <= to_input ^ (fault == 2'd2);
				pins.ack_n <= 1'b0;
				// Held long enough for the pin filter
				repeat (4) @(posedge clk);
				pins <= '1;
				repeat (6) @(posedge clk);
			end
		end
	end

endmodule : host_dma_model

// ==== fifo_dma_request_control_test.sv ====
// Self-checking bench of the FIFO DMA request engine
`timescale 1ns/1ps
module fifo_dma_request_control_test;
	import dma_req_pkg::*;

	localparam int DEPTH = 16;
	localparam int LW    = $clog2(DEPTH) + 1;

	logic          clk = 1'b0, rst_n = 1'b0;
	logic [7:0]    reg_addr = 8'h00;
	logic [31:0]   reg_wdata = 32'h0, reg_rdata;
	logic          reg_wr = 1'b0, reg_rd = 1'b0;
	host_pins_t    host_pins;
	logic          dma_request, dma_stop, in_wr, out_rd, flush;
	logic          pkt_ready, pkt_room, soft_reset = 1'b0;
	logic [LW-1:0] in_load = '0, out_load = '0, packet_words = '0;
	logic          m_en = 1'b0, m_in = 1'b1;
	logic [1:0]    m_fault = 2'd0;
	logic [3:0]    m_delay = 4'd0;
	logic [31:0]   in_count = 0, out_count = 0, failures = 0;
	logic [31:0]   comparisons = 0, cycles = 0;

	fifo_dma_request_control #(.FIFO_DEPTH(DEPTH)) u_fifo_dma_request_control (
		.CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .HOST_PINS(host_pins),
		.DMA_REQUEST(dma_request), .DMA_STOP(dma_stop),
		.IN_FIFO_LOAD(in_load), .OUT_FIFO_LOAD(out_load),
		.PACKET_WORDS(packet_words), .SOFT_RESET_CMD(soft_reset),
		.IN_FIFO_DMA_WRITE(in_wr), .OUT_FIFO_DMA_READ(out_rd),
		.FIFO_FLUSH(flush), .IN_PACKET_READY(pkt_ready),
		.OUT_PACKET_ROOM(pkt_room));

	host_dma_model u_host_dma_model (
		.clk(clk), .rst_n(rst_n), .enable(m_en), .to_input(m_in),
		.fault(m_fault), .delay(m_delay), .dma_req(dma_request),
		.pins(host_pins));

	initial forever #25 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (in_wr === 1'b1) in_count <= in_count + 1;
		if (out_rd === 1'b1) out_count <= out_count + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (failures == 0 && comparisons != 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic check(input string nm, input logic [31:0] e, g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check("reg_rdata", e, reg_rdata);
	endtask : reg_check

	task automatic wait_req(input logic lvl);
		int n;
		n = 0;
		while (dma_request !== lvl && n < 80) begin
			@(posedge clk);
			#1 n++;
		end
		check("dma_request", {31'h0, lvl}, {31'h0, dma_request});
	endtask : wait_req

	task automatic watch(input int n, output logic [31:0] rq, sp);
		rq = 0;
		sp = 0;
		repeat (n) begin
			@(posedge clk);
			#1 rq = rq + {31'h0, dma_request};
			sp = sp + {31'h0, dma_stop};
		end
	endtask : watch

	task automatic set_host(input logic en, input logic [1:0] f);
		@(posedge clk);
		m_en    <= en;
		m_fault <= f;
		if (!en) repeat (14) @(posedge clk);
	endtask : set_host

	////////////////////////////////////////////////////////////////////////
	task automatic t_registers();
		logic [31:0] rq, sp;
		reg_check(8'h88, 32'h0000000a);
		reg_check(8'h8c, (32'(OUT_LIMIT_RST[LW-1:0]) << OUT_LIMIT_LSB)
		          | (32'(STOP_LEN_RST) << STOP_LEN_LSB));
		reg_check(8'h90, 32'h00000001);
		reg_check(8'h40, 32'h00000000);
		watch(20, rq, sp);
		check("request while off", 0, rq);
	endtask : t_registers

	task automatic t_edge_input();
		logic [31:0] bi, bo, rq, sp;
		@(posedge clk) in_load <= LW'(10);
		reg_write(8'h90, 32'h3);
		wait_req(1'b1);
		bi = in_count;
		set_host(1'b1, 2'd1);
		repeat (30) @(posedge clk);
		set_host(1'b1, 2'd2);
		repeat (30) @(posedge clk);
		#1 check("ack without select", bi, in_count);
		check("dma_request", 1, {31'h0, dma_request});
		set_host(1'b0, 2'd0);
		bi = in_count;
		bo = out_count;
		set_host(1'b1, 2'd0);
		wait_req(1'b0);
		@(posedge clk);
		#1 check("words per ack", bi + 1, in_count);
		check("out words", bo, out_count);
		wait_req(1'b1);
		@(posedge clk) in_load <= LW'(11);
		wait_req(1'b0);
		watch(30, rq, sp);
		check("request above limit", 0, rq);
		set_host(1'b0, 2'd0);
	endtask : t_edge_input

	task automatic t_output();
		logic [31:0] bi, bo, rq, sp;
		reg_write(8'h8c, 32'h00010300);
		reg_check(8'h8c, 32'h00010300);
		reg_write(8'h90, 32'h2);
		watch(20, rq, sp);
		check("request empty out", 0, rq);
		@(posedge clk) out_load <= LW'(1);
		wait_req(1'b1);
		bi = in_count;
		bo = out_count;
		m_in <= 1'b0;
		set_host(1'b1, 2'd0);
		// Empty FIFO so the engine rests idle after this acknowledge
		out_load <= '0;
		wait_req(1'b0);
		@(posedge clk);
		#1 check("out words", bo + 1, out_count);
		check("in words", bi, in_count);
		set_host(1'b0, 2'd0);
		m_in <= 1'b1;
	endtask : t_output

	task automatic t_demand();
		logic [31:0] bi;
		reg_write(8'h88, DEPTH - 1);
		@(posedge clk) in_load <= LW'(13);
		reg_write(8'h90, 32'h7);
		wait_req(1'b1);
		bi = in_count;
		m_delay <= 4'd5;
		set_host(1'b1, 2'd0);
		wait_req(1'b0);
		@(posedge clk);
		#1 check("demand words", bi + 3, in_count);
		wait_req(1'b1);
		set_host(1'b0, 2'd0);
		m_delay <= 4'd0;
	endtask : t_demand

	task automatic t_disable();
		logic [31:0] rq, sp;
		#1 check("dma_request", 1, {31'h0, dma_request});
		reg_write(8'h90, 32'h5);
		watch(30, rq, sp);
		check("stop cycles", 3, sp);
		check("request after off", 0, rq);
		reg_write(8'h90, 32'h7);
		wait_req(1'b1);
		// Status: demand count 3 at bit 16, demand state, request up
		reg_check(8'h94, 32'h00030011);
	endtask : t_disable

	task automatic t_soft_reset();
		@(posedge clk) soft_reset <= 1'b1;
		@(posedge clk) soft_reset <= 1'b0;
		#1 check("fifo_flush", 1, {31'h0, flush});
		check("dma_request", 0, {31'h0, dma_request});
		@(posedge clk);
		#1 check("fifo_flush", 0, {31'h0, flush});
		reg_write(8'h90, 32'h1);
		repeat (30) @(posedge clk);
	endtask : t_soft_reset

	task automatic t_packet();
		@(posedge clk);
		packet_words <= LW'(5);
		in_load      <= LW'(5);
		out_load     <= LW'(11);
		repeat (3) @(posedge clk);
		#1 check("in ready", 1, {31'h0, pkt_ready});
		check("out room", 1, {31'h0, pkt_room});
		@(posedge clk);
		in_load  <= LW'(4);
		out_load <= LW'(12);
		repeat (3) @(posedge clk);
		#1 check("in ready", 0, {31'h0, pkt_ready});
		check("out room", 0, {31'h0, pkt_room});
	endtask : t_packet

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_registers();
		t_edge_input();
		t_output();
		t_demand();
		t_disable();
		t_soft_reset();
		t_packet();
		end_of_test();
	end

endmodule : fifo_dma_request_control_test
